// ---- rtl/gpio_ports_d_e_f.sv ----
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_ports_d_e_f (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   // wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [`ADDR_W-1:0]      wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   output logic                         wb_err_o,
   // port d pins
   input  wire gpio_pkg::byte_t         port_d_in,
   output gpio_pkg::byte_t              port_d_out,
   output gpio_pkg::byte_t              port_d_oe,
   output gpio_pkg::byte_t              port_d_pullup_on,
   // serial peripheral claims on port d
   input  wire gpio_pkg::byte_t         spi_pin_own,
   input  wire gpio_pkg::byte_t         spi_pin_oe,
   input  wire gpio_pkg::byte_t         spi_pin_out,
   // port e pins
   input  wire logic [`PORT_E_W-1:0]    port_e_in,
   output logic      [`PORT_E_W-1:0]    port_e_out,
   output logic      [`PORT_E_W-1:0]    port_e_oe,
   // enhanced serial interface
   input  wire logic                    serial_if_enable,
   input  wire logic                    serial_tx_data,
   output logic                         serial_rx_data,
   // port f pins
   input  wire gpio_pkg::byte_t         port_f_in,
   output gpio_pkg::byte_t              port_f_out,
   output gpio_pkg::byte_t              port_f_oe,
   // timer two channels 2..5 on port f upper pins
   input  wire gpio_pkg::timer_ch_t     timer_edge_level_select,
   input  wire gpio_pkg::timer_ch_t     timer_two_channel_oe,
   input  wire gpio_pkg::timer_ch_t     timer_two_channel_out,
   output gpio_pkg::timer_ch_t          timer_two_channel_pins
);
   import gpio_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_n;

   // async assert, synchronous release
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic [`ADDR_W-1:0] byte_adr;
   logic               req;
   logic               wr_lane0;
   logic               hit_d_data;
   logic               hit_e_data;
   logic               hit_f_data;
   logic               hit_d_dir;
   logic               hit_d_pue;
   logic               hit_e_dir;
   logic               hit_f_dir;
   logic               hit_any;
   logic               ack_q;
   logic               err_q;

   // offsets are not all word aligned, so they are indices
   assign byte_adr   = {wb_adr_i[`ADDR_W-3:0], 2'b00};
   assign req        = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
   assign wr_lane0   = req && hit_any && wb_we_i && wb_sel_i[0];
   assign hit_d_data = byte_adr == {`OFS_PORT_D_DATA, 2'b00};
   assign hit_e_data = byte_adr == {`OFS_PORT_E_DATA, 2'b00};
   assign hit_f_data = byte_adr == {`OFS_PORT_F_DATA, 2'b00};
   assign hit_d_dir  = byte_adr == {`OFS_PORT_D_DIR, 2'b00};
   assign hit_d_pue  = byte_adr == {`OFS_PORT_D_PUE, 2'b00};
   assign hit_e_dir  = byte_adr == {`OFS_PORT_E_DIR, 2'b00};
   assign hit_f_dir  = byte_adr == {`OFS_PORT_F_DIR, 2'b00};
   assign hit_any    = hit_d_data | hit_e_data | hit_f_data | hit_d_dir
                     | hit_d_pue | hit_e_dir | hit_f_dir;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   byte_t               d_latch_q;
   logic [`PORT_E_W-1:0] e_latch_q;
   byte_t               f_latch_q;
   byte_t               d_dir_q;
   byte_t               d_pue_q;
   logic [`PORT_E_W-1:0] e_dir_q;
   byte_t               f_dir_q;

   // data latches have no reset: power-up content is whatever it is
   always_ff @(posedge sys_clk) begin
      if (wr_lane0 && hit_d_data) d_latch_q <= wb_dat_i[7:0];
      if (wr_lane0 && hit_e_data) e_latch_q <= wb_dat_i[`PORT_E_W-1:0];
      if (wr_lane0 && hit_f_data) f_latch_q <= wb_dat_i[7:0];
   end

   // direction and pullup registers start cleared
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         d_dir_q <= `DIR_RESET;
         e_dir_q <= `PORT_E_W'(`DIR_RESET);
         f_dir_q <= `DIR_RESET;
         d_pue_q <= `PUE_RESET;
      end else begin
         if (wr_lane0 && hit_d_dir) d_dir_q <= wb_dat_i[7:0];
         if (wr_lane0 && hit_e_dir) e_dir_q <= wb_dat_i[`PORT_E_W-1:0];
         if (wr_lane0 && hit_f_dir) f_dir_q <= wb_dat_i[7:0];
         if (wr_lane0 && hit_d_pue) d_pue_q <= wb_dat_i[7:0];
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   byte_t               d_pin_s;
   logic [`PORT_E_W-1:0] e_pin_s;
   byte_t               f_pin_s;
   logic [23:0]         pins_raw;
   logic [23:0]         pins_s;

   assign pins_raw = {2'b00, port_e_in, port_f_in, port_d_in};
   assign d_pin_s  = pins_s[7:0];
   assign f_pin_s  = pins_s[15:8];
   assign e_pin_s  = pins_s[21:16];

   pin_sync #(.WIDTH(24)) u_sync (
      .clk        (sys_clk),
      .rst_sync_n (rst_sync_n),
      .async_in   (pins_raw),
      .sync_out   (pins_s)
   );

   // ------------------------------------------------------------
   // peripheral ownership
   // ------------------------------------------------------------
   logic [`PORT_E_W-1:0] e_own;
   logic [`PORT_E_W-1:0] e_per_oe;
   logic [`PORT_E_W-1:0] e_per_out;
   byte_t               f_own;
   byte_t               f_per_oe;
   byte_t               f_per_out;

   // serial: tx drives bit 0, rx holds bit 1 as input
   assign e_own     = {4'h0, serial_if_enable, serial_if_enable};
   assign e_per_oe  = {4'h0, 1'b0, 1'b1};
   assign e_per_out = {4'h0, 1'b0, serial_tx_data};
   // rx uses the synced pin so the serial logic sees no metastability
   assign serial_rx_data = e_pin_s[`PE_RX_BIT];
   // timer takes a pin only when its select field is nonzero
   assign f_own     = {timer_edge_level_select, 4'h0};
   assign f_per_oe  = {timer_two_channel_oe, 4'h0};
   assign f_per_out = {timer_two_channel_out, 4'h0};
   assign timer_two_channel_pins = f_pin_s[7:`PF_TIMER_LO];

   // ------------------------------------------------------------
   // pin muxes
   // ------------------------------------------------------------
   byte_t               d_rd;
   logic [`PORT_E_W-1:0] e_rd;
   byte_t               f_rd;

   gpio_port_bit #(.WIDTH(`PORT_D_W)) u_port_d (
      .latch      (d_latch_q),
      .dir        (d_dir_q),
      .periph_own (spi_pin_own),
      .periph_oe  (spi_pin_oe),
      .periph_out (spi_pin_out),
      .pin_level  (d_pin_s),
      .pin_out    (port_d_out),
      .pin_oe     (port_d_oe),
      .read_val   (d_rd)
   );

   gpio_port_bit #(.WIDTH(`PORT_E_W)) u_port_e (
      .latch      (e_latch_q),
      .dir        (e_dir_q),
      .periph_own (e_own),
      .periph_oe  (e_per_oe),
      .periph_out (e_per_out),
      .pin_level  (e_pin_s),
      .pin_out    (port_e_out),
      .pin_oe     (port_e_oe),
      .read_val   (e_rd)
   );

   gpio_port_bit #(.WIDTH(`PORT_F_W)) u_port_f (
      .latch      (f_latch_q),
      .dir        (f_dir_q),
      .periph_own (f_own),
      .periph_oe  (f_per_oe),
      .periph_out (f_per_out),
      .pin_level  (f_pin_s),
      .pin_out    (port_f_out),
      .pin_oe     (port_f_oe),
      .read_val   (f_rd)
   );

   // pullup only on pins that are inputs; also off while spi drives the pin
   assign port_d_pullup_on = d_pue_q & ~port_d_oe;

   // ------------------------------------------------------------
   // read mux and answer
   // ------------------------------------------------------------
   byte_t rd_mux;

   assign rd_mux = hit_d_data ? d_rd
                 : hit_e_data ? {2'b00, e_rd}
                 : hit_f_data ? f_rd
                 : hit_d_dir  ? d_dir_q
                 : hit_d_pue  ? d_pue_q
                 : hit_e_dir  ? {2'b00, e_dir_q}
                 : hit_f_dir  ? f_dir_q
                 : 8'h00;

   // one-cycle ack; unmapped addresses get err
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ack_q    <= 1'b0;
         err_q    <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_q    <= req && hit_any;
         err_q    <= req && !hit_any;
         wb_dat_o <= (req && hit_any && !wb_we_i) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
endmodule

// ---- rtl/gpio_consts.svh ----
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// register word indices on the wishbone address bus
`define OFS_PORT_D_DATA  12'h003
`define OFS_PORT_E_DATA  12'h008
`define OFS_PORT_F_DATA  12'h440
`define OFS_PORT_D_DIR   12'h004
`define OFS_PORT_D_PUE   12'h00C
`define OFS_PORT_E_DIR   12'h010
`define OFS_PORT_F_DIR   12'h444

// register index of printed offsets (byte address is four times the index)
`define ADDR_W           14

// widths of each port
`define PORT_D_W         8
`define PORT_E_W         6
`define PORT_F_W         8

// shared pin positions
`define PE_TX_BIT        0
`define PE_RX_BIT        1
`define PF_TIMER_LO      4

// reset value of direction and pullup registers
`define DIR_RESET        8'h00
`define PUE_RESET        8'h00

`endif

// ---- rtl/gpio_pkg.sv ----
package gpio_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] timer_ch_t;
endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of pin inputs
module pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_sync_n,
   // async pins and synced copy
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // elaboration check on the bundle width
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync width must be positive");
   end

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ---- rtl/gpio_port_bit.sv ----
`timescale 1ns/1ps
// one port's pin muxing: direction, output value, read value
module gpio_port_bit #(
   parameter int WIDTH = 8
) (
   // software state
   input  wire logic [WIDTH-1:0] latch,
   input  wire logic [WIDTH-1:0] dir,
   // peripheral ownership of pins
   input  wire logic [WIDTH-1:0] periph_own,
   input  wire logic [WIDTH-1:0] periph_oe,
   input  wire logic [WIDTH-1:0] periph_out,
   // synced pin level
   input  wire logic [WIDTH-1:0] pin_level,
   // pin drive and read mux
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe,
   output logic      [WIDTH-1:0] read_val
);
   // elaboration check: the read mux packs at most one byte
   if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("gpio_port_bit width out of range");
   end

   // per pin: peripheral overrides drive, direction always steers reads
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      assign pin_oe[i]   = periph_own[i] ? periph_oe[i] : dir[i];
      assign pin_out[i]  = periph_own[i] ? periph_out[i] : latch[i];
      assign read_val[i] = dir[i] ? latch[i] : pin_level[i];
   end
endmodule

// ---- test/gpio_ports_props.sv ----
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_ports_props (
   // clock, reset and bus
   input wire logic                 sys_clk,
   input wire logic                 rst_n,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [`ADDR_W-1:0]   wb_adr_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire logic                 wb_err_o,
   // pads and claims
   input wire gpio_pkg::byte_t      port_d_oe,
   input wire gpio_pkg::byte_t      port_d_pullup_on,
   input wire gpio_pkg::byte_t      spi_pin_own,
   input wire logic [`PORT_E_W-1:0] port_e_out,
   input wire logic [`PORT_E_W-1:0] port_e_oe,
   input wire logic                 serial_if_enable,
   input wire logic                 serial_tx_data,
   input wire gpio_pkg::byte_t      port_f_oe,
   input wire gpio_pkg::timer_ch_t  timer_edge_level_select,
   input wire gpio_pkg::timer_ch_t  timer_two_channel_oe
);
   import gpio_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // request decode; a held request is not taken again while its answer stands
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire hit = wb_adr_i inside {`OFS_PORT_D_DATA, `OFS_PORT_E_DATA, `OFS_PORT_F_DATA,
      `OFS_PORT_D_DIR, `OFS_PORT_D_PUE, `OFS_PORT_E_DIR, `OFS_PORT_F_DIR};
   wire wr0 = take && wb_we_i && wb_sel_i[0];
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_ans; take |=> (wb_ack_o ^ wb_err_o); endproperty
   a_ans: assert property (p_ans) else $error("request got no single answer");
   property p_pulse; (wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o; endproperty
   a_pulse: assert property (p_pulse) else $error("answer stood too long");
   property p_err; take && !hit |=> wb_err_o && !wb_ack_o; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_dir; wr0 && wb_adr_i == `OFS_PORT_D_DIR && spi_pin_own == 8'h00
      |=> port_d_oe == $past(wb_dat_i[7:0]); endproperty
   a_dir: assert property (p_dir) else $error("port d drive not per direction");
   property p_pue; wr0 && wb_adr_i == `OFS_PORT_D_PUE
      |=> port_d_pullup_on == ($past(wb_dat_i[7:0]) & ~port_d_oe); endproperty
   a_pue: assert property (p_pue) else $error("pullup not per enable");
   property p_puoff; (port_d_oe & port_d_pullup_on) == 8'h00; endproperty
   a_puoff: assert property (p_puoff) else $error("pullup on a driven pin");
   property p_tx; serial_if_enable |-> port_e_out[0] == serial_tx_data && port_e_oe[0]; endproperty
   a_tx: assert property (p_tx) else $error("transmit not on pin");
   property p_tmr; ((port_f_oe[7:4] ^ timer_two_channel_oe) & timer_edge_level_select) == 4'h0;
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer claim ignored");
   property p_rst; disable iff (1'b0) !rst_n [*3] |-> port_d_oe == 8'h00 && port_e_oe == 6'h00
      && port_f_oe == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("pin driven in reset");
   property p_ehi; wb_ack_o && !wb_we_i && (wb_adr_i == `OFS_PORT_E_DATA
      || wb_adr_i == `OFS_PORT_E_DIR) |-> wb_dat_o[7:6] == 2'b00; endproperty
   a_ehi: assert property (p_ehi) else $error("port e top bits not zero");
   // main scenarios reached
   cover property (wr0);
   cover property (take && !hit);
   cover property (serial_if_enable && port_e_oe[0]);
endmodule
bind gpio_ports_d_e_f gpio_ports_props i_gpio_ports_props (.*);

// ---- test/pin_board.sv ----
`timescale 1ns/1ps
module pin_board #(
   parameter int W = 8
) (
   // pad side of one port
   input wire logic         clk,
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] pu,
   // board drivers
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_v,
   output logic     [W-1:0] lvl
);
   logic [W-1:0] flt_q = '0;
   // undriven pads wander so a stale level never reads as a match
   always @(posedge clk) flt_q <= ~flt_q;
   // chip drive wins, then board, then internal pullup
   assign lvl = (oe & out) | (~oe & ext_en & ext_v) | (~oe & ~ext_en & (pu | flt_q));
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "gpio_consts.svh"
module tb;
   import gpio_pkg::*;
   logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, re;
   logic serial_if_enable, serial_tx_data, serial_rx_data;
   logic [13:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rq;
   byte_t port_d_in, port_d_out, port_d_oe, port_d_pullup_on, spi_pin_own, spi_pin_oe;
   byte_t spi_pin_out, port_f_in, port_f_out, port_f_oe;
   logic [5:0] port_e_in, port_e_out, port_e_oe;
   timer_ch_t timer_edge_level_select, timer_two_channel_oe, timer_two_channel_out;
   timer_ch_t timer_two_channel_pins;
   logic [7:0] ext_en [3];
   logic [7:0] ext_v [3];
   int n_errors, samples_checked;
   localparam logic [13:0] dat_a [3] = '{`OFS_PORT_D_DATA, `OFS_PORT_E_DATA, `OFS_PORT_F_DATA};
   localparam logic [13:0] dir_a [3] = '{`OFS_PORT_D_DIR, `OFS_PORT_E_DIR, `OFS_PORT_F_DIR};
   gpio_ports_d_e_f i_gpio_ports_d_e_f (.*);
   pin_board #(8) i_pin_board_d (.clk(sys_clk), .out(port_d_out), .oe(port_d_oe),
      .pu(port_d_pullup_on), .ext_en(ext_en[0]), .ext_v(ext_v[0]), .lvl(port_d_in));
   pin_board #(6) i_pin_board_e (.clk(sys_clk), .out(port_e_out), .oe(port_e_oe),
      .pu(6'h00), .ext_en(ext_en[1][5:0]), .ext_v(ext_v[1][5:0]), .lvl(port_e_in));
   pin_board #(8) i_pin_board_f (.clk(sys_clk), .out(port_f_out), .oe(port_f_oe),
      .pu(8'h00), .ext_en(ext_en[2]), .ext_v(ext_v[2]), .lvl(port_f_in));
   always #20 sys_clk = ~sys_clk;
   // pad views of one port, port e widened
   function automatic byte_t oe_of(int p);
      return p == 0 ? port_d_oe : p == 1 ? {2'b00, port_e_oe} : port_f_oe;
   endfunction
   function automatic byte_t out_of(int p);
      return p == 0 ? port_d_out : p == 1 ? {2'b00, port_e_out} : port_f_out;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle, held until ack or err is sampled high
   task automatic bus(logic w, logic [13:0] a, logic [7:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
      rq = wb_dat_o;
      re = wb_err_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (n >= 50) begin
         n_errors++;
         $display("BAD bus wait exp ack seen none");
         test_done();
      end
   endtask
   task automatic rst;
      rst_n <= 1'b0;
      tick(16);
      rst_n <= 1'b1;
      tick(4);
   endtask
   task automatic t_reset;
      for (int p = 0; p < 3; p++) begin
         bus(0, dir_a[p], 0);
         chk("dir", rq, 0);
         chk("oe", oe_of(p), 0);
      end
      bus(0, `OFS_PORT_D_PUE, 0);
      chk("pue", rq, 0);
   endtask
   task automatic t_port(int p);
      byte_t m;
      m = p == 1 ? 8'h3F : 8'hFF;
      ext_en[p] <= 8'hF0;
      ext_v[p] <= 8'h3C;
      bus(1, dat_a[p], 8'hA5);
      bus(1, dir_a[p], 8'h0F);
      tick(4);
      chk("oe", oe_of(p), 8'h0F);
      chk("out", out_of(p) & 8'h0F, 8'h05);
      bus(0, dat_a[p], 0);
      chk("rd", rq, 8'h35 & m);
      bus(1, dat_a[p], 8'h5A);
      bus(0, dat_a[p], 0);
      chk("rd", rq, 8'h3A & m);
      bus(1, dir_a[p], 0);
      ext_en[p] <= 8'h00;
   endtask
   task automatic t_pullup;
      bus(1, dir_a[0], 8'hF0);
      bus(1, `OFS_PORT_D_PUE, 8'hFF);
      tick(4);
      chk("pull", port_d_pullup_on, 8'h0F);
      bus(0, `OFS_PORT_D_PUE, 0);
      chk("pue", rq, 8'hFF);
      bus(0, dat_a[0], 0);
      chk("pin", rq[3:0], 4'hF);
      bus(1, `OFS_PORT_D_PUE, 8'h00);
      chk("pull", port_d_pullup_on, 0);
      bus(1, dir_a[0], 0);
   endtask
   task automatic t_serial;
      serial_if_enable <= 1'b1;
      serial_tx_data <= 1'b1;
      ext_en[1] <= 8'h02;
      ext_v[1] <= 8'h02;
      bus(1, dir_a[1], 8'h02);
      bus(1, dat_a[1], 8'hFD);
      tick(4);
      chk("e_oe", port_e_oe[1:0], 2'b01);
      chk("tx", port_e_out[0], 1'b1);
      chk("rx", serial_rx_data, 1'b1);
      bus(0, dat_a[1], 0);
      chk("e_rd", rq & 32'hC2, 0);
      serial_if_enable <= 1'b0;
      tick(2);
      chk("e_oe", port_e_oe[1:0], 2'b10);
      bus(1, dir_a[1], 0);
      ext_en[1] <= 8'h00;
   endtask
   task automatic t_timer;
      timer_edge_level_select <= 4'hA;
      timer_two_channel_oe <= 4'hF;
      ext_en[2] <= 8'hF0;
      ext_v[2] <= 8'h50;
      tick(4);
      chk("f_oe", port_f_oe, 8'hA0);
      chk("t_pin", timer_two_channel_pins, 4'h5);
      timer_edge_level_select <= 4'h0;
      ext_en[2] <= 8'h00;
   endtask
   task automatic t_spi;
      {spi_pin_own, spi_pin_oe, spi_pin_out} <= {8'h0F, 8'h0A, 8'h0F};
      bus(1, dir_a[0], 8'hF0);
      tick(2);
      chk("d_oe", port_d_oe, 8'hFA);
      chk("d_out", port_d_out & 8'h0A, 8'h0A);
      spi_pin_own <= 8'h00;
      bus(1, dir_a[0], 0);
   endtask
   task automatic t_keep;
      bus(1, dat_a[0], 8'h5A);
      bus(1, dir_a[0], 8'hFF);
      rst();
      chk("d_oe", port_d_oe, 0);
      bus(1, dir_a[0], 8'hFF);
      bus(0, dat_a[0], 0);
      chk("keep", rq, 8'h5A);
      bus(0, 14'h3FF, 0);
      chk("err", re, 1'b1);
   endtask
   // main sequence
   initial begin
      {sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      {serial_if_enable, serial_tx_data, spi_pin_own, spi_pin_oe, spi_pin_out} = '0;
      {timer_edge_level_select, timer_two_channel_oe, timer_two_channel_out} = '0;
      wb_sel_i = 4'hF;
      ext_en = '{default: 8'h00};
      ext_v = '{default: 8'h00};
      rst();
      t_reset();
      for (int p = 0; p < 3; p++) t_port(p);
      t_pullup();
      t_serial();
      t_timer();
      t_spi();
      t_keep();
      test_done();
   end
endmodule
